// ### core/emf_filter.sv
module emf_filter
    import encoder_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] sel,
    input wire logic [CHANNELS-1:0] raw,
    output logic [CHANNELS-1:0] filt
);
    // =========================================================
    // Sample tick
    logic [14:0] div_q;
    logic [14:0] limit;
    logic tick;
    always_comb begin
        unique case (sel)
            2'd0: limit = FILT_DIV0;
            2'd1: limit = FILT_DIV1;
            2'd2: limit = FILT_DIV2;
            2'd3: limit = FILT_DIV3;
        endcase
    end
    assign tick = (div_q >= limit - 15'd1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 15'd1;
        end
    end
    // =========================================================
    // Two equal samples in a row pass; spikes shorter than a tick die
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        logic last_q;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                last_q <= 1'b0;
                filt[i] <= 1'b0;
            end else if (tick) begin
                last_q <= raw[i];
                if (last_q == raw[i]) begin
                    filt[i] <= raw[i];
                end
            end
        end
    end
endmodule // emf_filter

// ### core/encoder_pkg.sv
package encoder_pkg;
    // =========================================================
    // Register map (byte addresses, one word each)
    localparam logic [4:0] ADDR_CONFIG = 5'h00;
    localparam logic [4:0] ADDR_MOTOR = 5'h04;
    localparam logic [4:0] ADDR_CONST = 5'h08;
    localparam logic [4:0] ADDR_POSITION = 5'h0C;
    localparam logic [4:0] ADDR_LATCH = 5'h10;
    localparam logic [4:0] ADDR_STATUS = 5'h14;
    localparam logic [4:0] ADDR_STATE = 5'h18;
    // =========================================================
    // encoder_mode_config fields
    localparam int CFG_SRC = 0;
    localparam int CFG_DECIMAL = 1;
    localparam int CFG_POL_A = 2;
    localparam int CFG_POL_B = 3;
    localparam int CFG_POL_N = 4;
    localparam int CFG_CLR_CONT = 5;
    localparam int CFG_CLR_ONCE = 6;
    localparam int CFG_CLR_ENC = 7;
    localparam int CFG_QSC_EN = 8;
    localparam int CFG_HYST_LO = 9;
    localparam int CFG_FILT_LO = 12;
    localparam int CFG_BLANK_LO = 16;
    localparam int CFG_DIAG_SEL = 24;
    localparam logic [31:0] CFG_MASK = 32'h01FF_3FFF;
    // =========================================================
    // Motor configuration fields
    localparam int MOT_FREEWHEEL_LO = 0;
    localparam int MOT_VOLTAGE_MODE = 2;
    localparam int MOT_HOLD_LO = 3;
    localparam int MOT_OFFTIME_LO = 8;
    localparam logic [31:0] MOT_MASK = 32'h0000_0FFF;
    // Status bits, write one to clear
    localparam int ST_CLEARED = 0;
    localparam int ST_LATCHED = 1;
    // =========================================================
    // Timing
    localparam int BLANK_SHIFT = 14;
    localparam int STANDSTILL_LOG2 = 20;
    localparam int FREEWHEEL_FREE = 1;
    localparam int FREEWHEEL_BRAKE = 2;
    localparam logic [16:0] FRAC_BINARY = 17'h1_0000;
    localparam logic [16:0] FRAC_DECIMAL = 17'h0_2710;
    // Filter dividers: clock/24600, /12300, /6150, /2870
    localparam logic [14:0] FILT_DIV0 = 15'h6018;
    localparam logic [14:0] FILT_DIV1 = 15'h300C;
    localparam logic [14:0] FILT_DIV2 = 15'h1806;
    localparam logic [14:0] FILT_DIV3 = 15'h0B36;
    // Threshold in mV per code 0..7
    localparam logic [7:0] HYST_MV [8] = '{8'h0A, 8'h19, 8'h32, 8'h4B,
                                          8'h64, 8'h96, 8'hC8, 8'hFA};
endpackage

// ### core/encoder_position_unit.sv
// Summary of operation
// [R1] Source bit 0: back-EMF decoder counts, only while standstill flag is set; the quiescence path (R5) also counts without standstill.
// [R2] Back-EMF decoder enabled only with freewheel setting 1 or 2; the quiescence path (R5) turns it on at any freewheel setting.
// [R3] Voltage mode: hold current and actual current must both be zero first.
// [R4] Cycle chopper mode: off time 0 disables bridges for freewheeling.
// [R5] Quiescence: decoder stays on with source 0 and quiescence enable 1.
// [R6] After standstill, coils ignored for blank field times 2^14 cycles.
// [R7] 3-bit threshold code maps to 10..250 mV.
// [R8] Standstill after programmable stepless time, default 2^20 cycles; ramp-down follows.
// [R9] Filter select picks clock/24600, /12300, /6150 or /2870.
// [R10] Filter bandwidth caps count rate at the filter frequency, one count per sample tick.
// [R11] Back-EMF counts full steps, each adding or subtracting the constant.
// [R12] Software may write the position; device updates it and returns it.
// [R13] Reset selects back-EMF source; set bit selects quadrature inputs.
// [R14] Continuous-index flag: every qualified index clears or latches.
// [R15] Once-index flag: next qualified index acts, then self-disables.
// [R16] Latch resets to 0, captures count at index after motion first starts.
// [R17] Latch event drives interrupt pin when diagnostic select bit routes it.
// [R18] Polarity flags qualify index by A and B levels.
// [R19] Index clear needs clear flag plus once or continuous flag.
// [R20] Status records index clear; latch captures position on every armed index once motion has started.
// [R21] Each A/B change adds or subtracts constant by direction.
// [R22] Constant is signed 16.16, binary mode two's complement.
// [R23] Decimal mode low half is 0..9999 tenth-thousandths.
// [R24] Direction from phase order: A leading B counts up.
module encoder_position_unit
    import encoder_pkg::*;
#(
    parameter int STANDSTILL_CYCLES = 1 << STANDSTILL_LOG2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic step_pulse,
    input wire logic [4:0] current_scale,
    input wire logic quiescence_active,
    input wire logic emf_a,
    input wire logic emf_b,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_n,
    output logic bridge_disable,
    output logic [7:0] threshold_mv,
    output logic standstill,
    output logic ramp_down_start,
    output logic decoder_active,
    output logic diagnostic_output_zero
);
    if (STANDSTILL_CYCLES < 2 || STANDSTILL_CYCLES > (1 << 24)) begin : g_chk
        $error("STANDSTILL_CYCLES out of range");
    end

    // =========================================================
    // Registers
    logic [31:0] config_q;
    logic [31:0] motor_q;
    logic [31:0] const_q;
    logic [31:0] position_q;
    logic [16:0] frac_q;
    logic [31:0] latch_q;
    logic [1:0] status_q;
    logic ack_q;
    logic take;
    logic wr_take;

    // One wait cycle, then the answer
    assign waitrequest = (read | write) & ~ack_q;
    assign take = (read | write) & ack_q;
    assign wr_take = write & ack_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    // =========================================================
    // Field views
    logic src_abn;
    logic decimal_mode;
    logic [2:0] hyst_sel;
    logic [1:0] filt_sel;
    logic [7:0] blank_field;
    logic [1:0] freewheel;
    logic voltage_mode;
    logic [4:0] hold_current;
    logic [3:0] off_time;

    assign src_abn = config_q[CFG_SRC];
    assign decimal_mode = config_q[CFG_DECIMAL];
    assign hyst_sel = config_q[CFG_HYST_LO +: 3];
    assign filt_sel = config_q[CFG_FILT_LO +: 2];
    assign blank_field = config_q[CFG_BLANK_LO +: 8];
    assign freewheel = motor_q[MOT_FREEWHEEL_LO +: 2];
    assign voltage_mode = motor_q[MOT_VOLTAGE_MODE];
    assign hold_current = motor_q[MOT_HOLD_LO +: 5];
    assign off_time = motor_q[MOT_OFFTIME_LO +: 4];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_q <= '0;
            const_q <= '0;
        end else if (wr_take) begin
            if (address == ADDR_MOTOR) begin
                motor_q <= writedata & MOT_MASK;
            end
            if (address == ADDR_CONST) begin
                const_q <= writedata; // [R22] [R23]
            end
        end
    end

    // =========================================================
    // Standstill detection
    logic [24:0] still_cnt_q;
    logic standstill_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            still_cnt_q <= '0;
            standstill_q <= 1'b0;
        end else if (step_pulse) begin
            still_cnt_q <= '0;
            standstill_q <= 1'b0;
        end else if (still_cnt_q == 25'(STANDSTILL_CYCLES - 1)) begin
            standstill_q <= 1'b1; // [R8]
        end else begin
            still_cnt_q <= still_cnt_q + 25'd1;
        end
    end
    assign standstill = standstill_q;
    assign ramp_down_start = (still_cnt_q == 25'(STANDSTILL_CYCLES - 1))
        & ~standstill_q & ~step_pulse; // [R8]

    // =========================================================
    // Blanking after standstill, so decaying coil current is not seen as motion
    logic [BLANK_SHIFT+7:0] blank_cnt_q;
    logic blank_done_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blank_cnt_q <= '0;
            blank_done_q <= 1'b0;
        end else if (!standstill_q) begin
            blank_cnt_q <= '0;
            blank_done_q <= 1'b0;
        end else if (blank_cnt_q >= {blank_field, BLANK_SHIFT'(0)}) begin
            blank_done_q <= 1'b1; // [R6]
        end else begin
            blank_cnt_q <= blank_cnt_q + (BLANK_SHIFT+8)'(1);
        end
    end

    // =========================================================
    // Decoder enable
    logic freewheel_ok;
    logic current_ok;
    logic normal_en;
    logic quiet_en;
    assign freewheel_ok = (freewheel == 2'(FREEWHEEL_FREE))
        | (freewheel == 2'(FREEWHEEL_BRAKE)); // [R2]
    // Voltage mode waits for the current scale to fall to zero
    assign current_ok = voltage_mode ? (hold_current == '0) & (current_scale == '0) // [R3]
                                     : (off_time == '0); // [R4]
    assign normal_en = ~src_abn & standstill_q & blank_done_q
        & freewheel_ok & current_ok; // [R1] [R6]
    assign quiet_en = quiescence_active & ~src_abn & config_q[CFG_QSC_EN]; // [R5]
    assign decoder_active = normal_en | quiet_en;
    // Bridges off only for freewheeling decode; a zero off time in cycle mode keeps them off
    assign bridge_disable = (~voltage_mode & (off_time == '0))
        | (normal_en & freewheel == 2'(FREEWHEEL_FREE)); // [R4]
    assign threshold_mv = HYST_MV[hyst_sel]; // [R7]

    // =========================================================
    // Signal decoding
    logic [1:0] emf_filt;
    logic emf_step;
    logic emf_up;
    logic abn_step;
    logic abn_up;

    emf_filter #(.CHANNELS(2)) u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .sel(filt_sel), // [R9] [R10]
        .raw({emf_b, emf_a}),
        .filt(emf_filt)
    );
    quad_step u_emf_dec (
        .clk(clk),
        .rst_n(rst_n),
        .a(emf_filt[0]),
        .b(emf_filt[1]),
        .step(emf_step),
        .up(emf_up)
    );
    quad_step u_abn_dec (
        .clk(clk),
        .rst_n(rst_n),
        .a(enc_a),
        .b(enc_b),
        .step(abn_step),
        .up(abn_up)
    );

    logic count_step;
    logic count_up;
    always_comb begin
        if (src_abn) begin
            count_step = abn_step; // [R13] [R21]
            count_up = abn_up; // [R24]
        end else begin
            count_step = emf_step & decoder_active; // [R1] [R11]
            count_up = emf_up; // [R24]
        end
    end

    // =========================================================
    // Index qualification
    logic n_q;
    logic motion_q;
    logic index_event;
    logic pol_ok;
    assign pol_ok = (enc_a == config_q[CFG_POL_A])
        & (enc_b == config_q[CFG_POL_B]); // [R18]
    assign index_event = src_abn & (enc_n == config_q[CFG_POL_N])
        & (n_q != config_q[CFG_POL_N]) & pol_ok;

    logic arm;
    logic do_clear;
    logic do_latch;
    assign arm = config_q[CFG_CLR_CONT] | config_q[CFG_CLR_ONCE]; // [R14] [R15]
    assign do_latch = index_event & arm & motion_q; // [R16] [R20]
    assign do_clear = index_event & arm & config_q[CFG_CLR_ENC]; // [R19]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_q <= 1'b0;
            motion_q <= 1'b0;
        end else begin
            n_q <= enc_n;
            if (count_step) begin
                motion_q <= 1'b1;
            end
        end
    end

    // Once flag drops itself after its event; a write in the same cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= '0; // [R13]
        end else if (wr_take && address == ADDR_CONFIG) begin
            config_q <= writedata & CFG_MASK;
        end else if (index_event && config_q[CFG_CLR_ONCE]) begin
            config_q[CFG_CLR_ONCE] <= 1'b0; // [R15]
        end
    end

    // =========================================================
    // Position accumulator, fraction modulo 65536 or 10000
    logic [16:0] modulus;
    logic [15:0] inc_int;
    logic [16:0] inc_frac;
    logic [17:0] frac_sum;
    logic [17:0] frac_diff;
    logic [16:0] frac_next;
    logic [31:0] pos_next;
    logic carry;

    assign modulus = decimal_mode ? FRAC_DECIMAL : FRAC_BINARY; // [R22] [R23]
    assign inc_int = const_q[31:16];
    assign inc_frac = {1'b0, const_q[15:0]};
    assign frac_sum = {1'b0, frac_q} + {1'b0, inc_frac};
    assign frac_diff = {1'b0, frac_q} - {1'b0, inc_frac};

    always_comb begin
        frac_next = frac_q;
        carry = 1'b0;
        pos_next = position_q;
        if (count_up) begin
            if (frac_sum >= {1'b0, modulus}) begin
                frac_next = 17'(frac_sum - {1'b0, modulus});
                carry = 1'b1;
            end else begin
                frac_next = frac_sum[16:0];
            end
            pos_next = position_q + {{16{inc_int[15]}}, inc_int} + 32'(carry); // [R21]
        end else begin
            if (frac_diff[17]) begin
                frac_next = 17'(frac_diff + {1'b0, modulus});
                carry = 1'b1;
            end else begin
                frac_next = frac_diff[16:0];
            end
            pos_next = position_q - {{16{inc_int[15]}}, inc_int} - 32'(carry); // [R21]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            position_q <= '0;
            frac_q <= '0;
        end else if (wr_take && address == ADDR_POSITION) begin
            position_q <= writedata; // [R12]
            frac_q <= '0;
        end else if (do_clear) begin
            position_q <= '0; // [R19]
            frac_q <= '0;
        end else if (count_step) begin
            position_q <= pos_next; // [R11] [R21]
            frac_q <= frac_next;
        end
    end

    // =========================================================
    // Latch and status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= '0; // [R16]
        end else if (do_latch) begin
            latch_q <= position_q; // [R20]
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_take && address == ADDR_STATUS && writedata[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
            if (do_clear) begin
                status_q[ST_CLEARED] <= 1'b1; // [R20]
            end
            if (do_latch) begin
                status_q[ST_LATCHED] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            diagnostic_output_zero <= 1'b0;
        end else begin
            diagnostic_output_zero <= config_q[CFG_DIAG_SEL]
                & status_q[ST_LATCHED]; // [R17]
        end
    end

    // =========================================================
    // Read data, captured in the wait cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= '0;
        end else if (read && !ack_q) begin
            unique case (address)
                ADDR_CONFIG: readdata <= config_q;
                ADDR_MOTOR: readdata <= motor_q;
                ADDR_CONST: readdata <= const_q;
                ADDR_POSITION: readdata <= position_q; // [R12]
                ADDR_LATCH: readdata <= latch_q;
                ADDR_STATUS: readdata <= {30'h0000_0000, status_q};
                ADDR_STATE: readdata <= {29'h0000_0000, motion_q,
                                         decoder_active, standstill_q};
                default: readdata <= '0;
            endcase
        end
    end

endmodule // encoder_position_unit

// ### core/quad_step.sv
module quad_step (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic a,
    input wire logic b,
    output logic step,
    output logic up
);
    logic a_q;
    logic b_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= a;
            b_q <= b;
        end
    end
    // A double change has no direction and is dropped
    assign step = (a ^ a_q) ^ (b ^ b_q);
    assign up = a ^ b_q;
endmodule // quad_step

// ### test/encoder_position_unit_sva.sv
module encoder_position_unit_sva #(
    parameter int STANDSTILL_CYCLES = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic step_pulse,
    input wire logic quiescence_active,
    input wire logic [7:0] threshold_mv,
    input wire logic standstill,
    input wire logic ramp_down_start,
    input wire logic decoder_active
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Bus and timing checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence req_s;
        (read || write) && waitrequest;
    endsequence
    sequence held_s;
        req_s ##1 (read || write);
    endsequence
    bus_answer_a: assert property (held_s |-> !waitrequest)
        else $error("bus answer late");
    bus_idle_a: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest while idle");
    read_hold_a: assert property (!read |=> $stable(readdata))
        else $error("read data moved");
    thr_code_a: assert property (threshold_mv inside {8'h0A, 8'h19, 8'h32, 8'h4B,
        8'h64, 8'h96, 8'hC8, 8'hFA})
        else $error("threshold outside table");
    ramp_next_a: assert property (ramp_down_start |=> $rose(standstill))
        else $error("ramp pulse without standstill");
    ramp_first_a: assert property ($rose(standstill) |-> $past(ramp_down_start))
        else $error("standstill without ramp pulse");
    step_quiet_a: assert property (step_pulse |=> !ramp_down_start [*8])
        else $error("standstill too soon after step");
    step_clear_a: assert property (step_pulse |-> ##[1:2] !standstill)
        else $error("step did not end standstill");
    dec_need_a: assert property (decoder_active |-> standstill || quiescence_active)
        else $error("decoder active while moving");
    blank_first_a: assert property ($rose(standstill) && !quiescence_active
        |-> !decoder_active)
        else $error("decoder active before blanking");
endmodule // encoder_position_unit_sva

bind encoder_position_unit encoder_position_unit_sva #(
    .STANDSTILL_CYCLES(STANDSTILL_CYCLES)
) i_sva (.*);

// ### test/quad_encoder_model.sv
module quad_encoder_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic move,
    input wire logic up,
    input wire logic index_req,
    output logic enc_a,
    output logic enc_b,
    output logic enc_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Gray phase: 00, 10, 11, 01 when turning up
    logic [1:0] phase_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 2'b00;
            enc_n <= 1'b0;
        end else begin
            enc_n <= index_req;
            if (move) begin
                phase_q <= up ? phase_q + 2'b01 : phase_q - 2'b01;
            end
        end
    end
    // One line changes per move
    assign enc_a = phase_q[0] ^ phase_q[1];
    assign enc_b = phase_q[1];
endmodule // quad_encoder_model

// ### test/tb_encoder_position_unit.sv
module tb_encoder_position_unit
    import encoder_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_n = 1'b0, read = 1'b0, write = 1'b0, step_pulse = 1'b0, emf_a = 1'b0;
    logic quiescence_active = 1'b0, emf_b = 1'b0, mv = 1'b0, up = 1'b0, pn = 1'b0;
    logic [1:0] ph = 2'b00;
    logic [4:0] address = 5'h00;
    logic [4:0] current_scale = 5'h00;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic waitrequest, enc_a, enc_b, enc_n, bridge_disable, standstill;
    logic ramp_down_start, decoder_active, diagnostic_output_zero;
    logic [7:0] threshold_mv;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    encoder_position_unit #(.STANDSTILL_CYCLES(64)) i_dut (.*);
    quad_encoder_model i_enc (.clk(clk), .rst_n(rst_n), .move(mv), .up(up),
        .index_req(pn), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));
    // =========================================================
    // Tasks
    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic mov(input logic u);
        @(posedge clk);
        mv <= 1'b1;
        up <= u;
        @(posedge clk);
        mv <= 1'b0;
        ph = u ? ph + 2'b01 : ph - 2'b01;
        repeat (3) @(posedge clk);
    endtask
    task automatic idx();
        @(posedge clk);
        pn <= 1'b1;
        @(posedge clk);
        pn <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic still();
        @(posedge clk);
        step_pulse <= 1'b1;
        @(posedge clk);
        step_pulse <= 1'b0;
        repeat (60) @(negedge clk);
        chk(32'(standstill), 32'h0000_0000);
        repeat (8) @(negedge clk);
        chk(32'(standstill), 32'h0000_0001);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // =========================================================
    // Main sequence
    initial begin
        int k;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk(ADDR_CONFIG, 32'h0000_0000);
        rchk(ADDR_LATCH, 32'h0000_0000);
        bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
        rchk(5'h1C, 32'h0000_0000);
        bus(1'b1, ADDR_CONST, 32'h0001_0000);
        bus(1'b1, ADDR_CONFIG, 32'h0000_0001);
        bus(1'b1, ADDR_POSITION, 32'h0000_1234);
        rchk(ADDR_POSITION, 32'h0000_1234);
        bus(1'b1, ADDR_POSITION, 32'h0000_0000);
        repeat (4) mov(1'b1);
        mov(1'b0);
        rchk(ADDR_POSITION, 32'h0000_0003);
        bus(1'b1, ADDR_CONST, 32'hFFFF_0000);
        mov(1'b1);
        rchk(ADDR_POSITION, 32'h0000_0002);
        bus(1'b1, ADDR_CONFIG, 32'h0000_0003);
        bus(1'b1, ADDR_CONST, 32'h0019_1770);
        bus(1'b1, ADDR_POSITION, 32'h0000_0000);
        repeat (2) mov(1'b1);
        rchk(ADDR_POSITION, 32'h0000_0033);
        bus(1'b1, ADDR_CONST, 32'hFFE6_0FA0);
        bus(1'b1, ADDR_POSITION, 32'h0000_0000);
        mov(1'b1);
        rchk(ADDR_POSITION, 32'hFFFF_FFE6);
        // Index: A and B high, once, clear, pin routed
        bus(1'b1, ADDR_CONST, 32'h0001_0000);
        bus(1'b1, ADDR_CONFIG, 32'h0100_00DD);
        bus(1'b1, ADDR_POSITION, 32'h0000_0000);
        k = 0;
        while (ph != 2'b10) begin
            mov(1'b1);
            k++;
        end
        idx();
        rchk(ADDR_POSITION, 32'h0000_0000);
        rchk(ADDR_LATCH, 32'(k));
        rchk(ADDR_STATUS, 32'h0000_0003);
        rchk(ADDR_CONFIG, 32'h0100_009D);
        chk(32'(diagnostic_output_zero), 32'h0000_0001);
        bus(1'b1, ADDR_STATUS, 32'h0000_0003);
        rchk(ADDR_STATUS, 32'h0000_0000);
        chk(32'(diagnostic_output_zero), 32'h0000_0000);
        repeat (4) mov(1'b1);
        idx();
        rchk(ADDR_POSITION, 32'h0000_0004);
        bus(1'b1, ADDR_CONFIG, 32'h0100_00BD);
        idx();
        rchk(ADDR_POSITION, 32'h0000_0000);
        repeat (8) mov(1'b1);
        idx();
        rchk(ADDR_POSITION, 32'h0000_0000);
        rchk(ADDR_LATCH, 32'h0000_0008);
        mov(1'b1);
        idx();
        rchk(ADDR_POSITION, 32'h0000_0001);
        bus(1'b1, ADDR_CONFIG, 32'h0100_003D);
        repeat (11) mov(1'b1);
        idx();
        rchk(ADDR_POSITION, 32'h0000_000C);
        rchk(ADDR_LATCH, 32'h0000_000C);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, ADDR_CONFIG, 32'(i) << 9);
            @(negedge clk) chk(32'(threshold_mv), 32'(HYST_MV[i]));
        end
        // Back-EMF path: fastest filter, no blanking, freewheel
        bus(1'b1, ADDR_CONFIG, 32'h0000_3000);
        bus(1'b1, ADDR_MOTOR, 32'h0000_0001);
        bus(1'b1, ADDR_CONST, 32'h0100_0000);
        bus(1'b1, ADDR_POSITION, 32'h0000_0000);
        still();
        repeat (2) @(negedge clk);
        chk(32'({decoder_active, bridge_disable}), 32'h0000_0003);
        @(posedge clk) emf_a <= 1'b1;
        repeat (9000) @(posedge clk);
        emf_b <= 1'b1;
        repeat (9000) @(posedge clk);
        rchk(ADDR_POSITION, 32'h0000_0200);
        rchk(ADDR_STATE, 32'h0000_0007);
        bus(1'b1, ADDR_MOTOR, 32'h0000_0000);
        @(negedge clk) chk(32'(decoder_active), 32'h0000_0000);
        bus(1'b1, ADDR_MOTOR, 32'h0000_0301);
        @(negedge clk) chk(32'({decoder_active, bridge_disable}), 32'h0000_0000);
        @(posedge clk) current_scale <= 5'h03;
        bus(1'b1, ADDR_MOTOR, 32'h0000_0005);
        @(negedge clk) chk(32'(decoder_active), 32'h0000_0000);
        @(posedge clk) current_scale <= 5'h00;
        @(negedge clk) chk(32'(decoder_active), 32'h0000_0001);
        bus(1'b1, ADDR_MOTOR, 32'h0000_0000);
        bus(1'b1, ADDR_CONFIG, 32'h0000_3100);
        quiescence_active <= 1'b1;
        @(negedge clk) chk(32'(decoder_active), 32'h0000_0001);
        bus(1'b1, ADDR_CONFIG, 32'h0000_3101);
        @(negedge clk) chk(32'(decoder_active), 32'h0000_0000);
        @(posedge clk) quiescence_active <= 1'b0;
        bus(1'b1, ADDR_MOTOR, 32'h0000_0001);
        bus(1'b1, ADDR_CONFIG, 32'h0001_3000);
        still();
        repeat (100) @(negedge clk);
        chk(32'(decoder_active), 32'h0000_0000);
        repeat (16400) @(negedge clk);
        chk(32'(decoder_active), 32'h0000_0001);
        tally_and_finish();
    end
endmodule // tb_encoder_position_unit
